// *** rtl/meter_host_if_pkg.sv ***
// Behaviour
// - all three boot straps low at reset release starts the byte-wide boot
// - boot image is 96 header, 243 setup, then 20136 code bytes
// - code segment rewrites program words from address zero, covering first 113
// - after the last code byte the device starts running by itself
// - no boot byte is read while bus request is asserted
// - after release the device reads the byte and pulses boot memory select
// - metering starts only after 154 framed bytes arrive on the serial link
// - first four bytes clocked after start, framed or not, return the checksum of all boot image bytes
// - host is serial master and clock source, device shifts as slave
// - a byte whose first bit sees control low is a valid command byte
// - while metering, a fresh parameter set every 32 line cycles
// - after a request, ready flag falls when the next computation ends
// - answer train is at most 522 bytes, host may stop early
// - four-byte quantities go out least significant word first
package meter_host_if_pkg;

    // ---------------------------------------------------------------
    // boot image layout and counts
    // ---------------------------------------------------------------
    localparam logic [14:0] HDR_BYTES = 15'h0060;
    localparam logic [14:0] SETUP_BYTES = 15'h00F3;
    localparam logic [14:0] CODE_BYTES = 15'h4EA8;
    localparam logic [12:0] OVERWRITE_WORDS = 13'h0071;
    localparam logic [1:0] WORD_LAST_BYTE = 2'h2;
    localparam logic [7:0] INIT_BYTES = 8'h9A;
    localparam logic [7:0] CSUM_BYTES = 8'h04;
    localparam logic [5:0] LINE_CYCLES = 6'h20;
    localparam logic [7:0] REQ_CODE = 8'h45;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [9:0] TRAIN_MAX = 10'h20A;
    localparam logic [2:0] QTY_BYTES_4 = 3'h4;
    localparam logic [2:0] QTY_BYTES_2 = 3'h2;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_BOOT_WAIT = 3'b001,
        ST_BOOT_ACK = 3'b010,
        ST_INIT = 3'b011,
        ST_METER = 3'b100
    } state_t;

    typedef enum logic [1:0] {
        SEG_HDR = 2'b00,
        SEG_SETUP = 2'b01,
        SEG_CODE = 2'b10
    } seg_t;

    // length of each boot segment in bytes
    function automatic logic [14:0] seg_len(input seg_t seg);
        case (seg)
            SEG_HDR: seg_len = HDR_BYTES;
            SEG_SETUP: seg_len = SETUP_BYTES;
            default: seg_len = CODE_BYTES;
        endcase
    endfunction : seg_len

    // byte order on the wire: low word first, each word high byte first
    function automatic logic [7:0] pick_byte(input logic [31:0] v, input logic [2:0] size, input logic [1:0] pos);
        if (size == QTY_BYTES_4)
            case (pos)
                2'h0: pick_byte = v[15:8];
                2'h1: pick_byte = v[7:0];
                2'h2: pick_byte = v[31:24];
                default: pick_byte = v[23:16];
            endcase
        else if (size == QTY_BYTES_2)
            pick_byte = (pos == 2'h0) ? v[15:8] : v[7:0];
        else
            pick_byte = v[7:0];
    endfunction : pick_byte

endpackage : meter_host_if_pkg

// *** rtl/host_boot_and_spi_link.sv ***
`timescale 1ns/100ps
module host_boot_and_spi_link
    import meter_host_if_pkg::*;
(
    input wire logic sys_clk_i, // core clock, 125 MHz
    input wire logic rst_i, // async reset, active high
    input wire logic dev_reset_n_i, // reset pin driven by the host
    input wire logic [2:0] boot_strap_i, // boot mode straps
    input wire logic bus_request_n_i, // bus request from external flip-flop
    input wire logic [7:0] boot_data_i, // boot byte on upper data lines
    output logic boot_memory_select_n_o, // read strobe, presets the flip-flop
    output logic bus_grant_o, // buses granted to the host
    output logic prog_we_o, // program word write pulse
    output logic [12:0] prog_addr_o, // program word address
    output logic [23:0] prog_word_o, // assembled 24-bit program word
    output logic running_o, // loaded code is executing
    output logic metering_o, // initialization done, metering active
    input wire logic line_cycle_i, // one pulse per power-line cycle
    output logic compute_done_o, // fresh parameter set pulse
    output logic [6:0] qty_index_o, // quantity index into parameter store
    input wire logic [31:0] qty_value_i, // quantity value, same clock
    input wire logic [2:0] qty_size_i, // quantity size in bytes
    output logic data_ready_flag_n_o, // ready flag, falls when data waits
    input wire logic spi_sclk_i, // serial clock from the host
    input wire logic spi_mosi_i, // serial data in
    input wire logic ctrl_frame_n_i, // host write framing line
    output logic spi_miso_o // serial data out
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    localparam int SW = 16;
    logic [SW-1:0] sync1_r, sync2_r;
    logic [2:0] edge_r;
    logic rx_tgl_l, fs_tgl_l, rx_framed_l;
    logic dev_rst_n_s, br_n_s, line_s, rx_tgl_s, fs_tgl_s;
    logic [2:0] strap_s;
    logic [7:0] data_s;

    // first stage feeds only the second
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
        end
        else
        begin
            sync1_r <= {dev_reset_n_i, bus_request_n_i, line_cycle_i, boot_strap_i, boot_data_i, rx_tgl_l, fs_tgl_l};
            sync2_r <= sync1_r;
        end
    end

    assign {dev_rst_n_s, br_n_s, line_s, strap_s, data_s, rx_tgl_s, fs_tgl_s} = sync2_r;

    // delayed copies for edge detection
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            edge_r <= 3'h0;
        end
        else
        begin
            edge_r <= {line_s, rx_tgl_s, fs_tgl_s};
        end
    end

    logic line_evt, rx_evt, fs_evt;
    assign line_evt = line_s & ~edge_r[2];
    assign rx_evt = rx_tgl_s ^ edge_r[1];
    assign fs_evt = fs_tgl_s ^ edge_r[0];

    // ---------------------------------------------------------------
    // boot loader
    // ---------------------------------------------------------------
    state_t state_r;
    seg_t seg_r;
    logic [14:0] byte_cnt_r;
    logic [1:0] wbyte_r;
    logic [15:0] word_hi_r;
    logic [12:0] waddr_r;
    logic boot_done_r;
    logic [31:0] csum_r;
    logic [7:0] init_cnt_r;
    logic byte_take, last_of_seg;

    // a byte is taken only once the host has released bus request
    assign byte_take = (state_r == ST_BOOT_WAIT) && br_n_s;
    assign last_of_seg = (byte_cnt_r == seg_len(seg_r) - 15'h0001);

    // main sequence; the device pin reset returns it to ST_HOLD
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_HOLD;
        end
        else if (!dev_rst_n_s)
        begin
            state_r <= ST_HOLD;
        end
        else
        begin
            case (state_r)
                ST_HOLD: state_r <= (strap_s == 3'h0) ? ST_BOOT_WAIT : ST_INIT;
                ST_BOOT_WAIT: if (byte_take) state_r <= ST_BOOT_ACK;
                ST_BOOT_ACK: if (!br_n_s) state_r <= boot_done_r ? ST_INIT : ST_BOOT_WAIT;
                ST_INIT: if (rx_evt && rx_framed_l && init_cnt_r == INIT_BYTES - 8'h01) state_r <= ST_METER;
                ST_METER: state_r <= ST_METER;
                default: state_r <= ST_HOLD;
            endcase
        end
    end

    // segment and byte counting; segments follow back to back
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            seg_r <= SEG_HDR;
            byte_cnt_r <= 15'h0000;
            boot_done_r <= 1'b0;
            csum_r <= 32'h0000_0000;
        end
        else if (state_r == ST_HOLD)
        begin
            seg_r <= SEG_HDR;
            byte_cnt_r <= 15'h0000;
            boot_done_r <= 1'b0;
            csum_r <= 32'h0000_0000;
        end
        else if (byte_take)
        begin
            csum_r <= csum_r + {24'h000000, data_s};
            byte_cnt_r <= last_of_seg ? 15'h0000 : byte_cnt_r + 15'h0001;
            if (last_of_seg && seg_r == SEG_HDR)
                seg_r <= SEG_SETUP;
            else if (last_of_seg && seg_r == SEG_SETUP)
                seg_r <= SEG_CODE;
            else if (last_of_seg)
                boot_done_r <= 1'b1;
        end
    end

    // three bytes per program word, first byte most significant
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wbyte_r <= 2'h0;
            word_hi_r <= 16'h0000;
            waddr_r <= 13'h0000;
            prog_we_o <= 1'b0;
            prog_addr_o <= 13'h0000;
            prog_word_o <= 24'h000000;
        end
        else
        begin
            prog_we_o <= 1'b0;
            if (state_r == ST_HOLD)
            begin
                wbyte_r <= 2'h0;
                waddr_r <= 13'h0000;
            end
            else if (byte_take)
            begin
                wbyte_r <= (wbyte_r == WORD_LAST_BYTE || last_of_seg) ? 2'h0 : wbyte_r + 2'h1;
                word_hi_r <= {word_hi_r[7:0], data_s};
                if (wbyte_r == WORD_LAST_BYTE)
                begin
                    prog_we_o <= 1'b1;
                    prog_addr_o <= waddr_r;
                    prog_word_o <= {word_hi_r, data_s};
                end
                // code load restarts at word zero over the loader words
                if (last_of_seg && seg_r == SEG_SETUP)
                    waddr_r <= 13'h0000;
                else if (wbyte_r == WORD_LAST_BYTE)
                    waddr_r <= waddr_r + 13'h0001;
            end
        end
    end

    // select strobe presets the flip-flop, which re-asserts bus request
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            boot_memory_select_n_o <= 1'b1;
            bus_grant_o <= 1'b0;
        end
        else
        begin
            boot_memory_select_n_o <= ~(byte_take || (state_r == ST_BOOT_ACK && br_n_s));
            bus_grant_o <= (state_r == ST_BOOT_WAIT || state_r == ST_BOOT_ACK) && !br_n_s;
        end
    end

    // ---------------------------------------------------------------
    // serial link, host clock domain
    // ---------------------------------------------------------------
    logic [2:0] bit_cnt_l;
    logic [6:0] rx_shift_l;
    logic [7:0] rx_byte_l, tx_shift_l, tx_byte_r;
    logic frame_ctrl_l;

    // sample on the falling edge; host drives data on the rising edge
    always_ff @(negedge spi_sclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bit_cnt_l <= 3'h0;
            rx_shift_l <= 7'h00;
            rx_byte_l <= 8'h00;
            frame_ctrl_l <= 1'b0;
            rx_framed_l <= 1'b0;
            rx_tgl_l <= 1'b0;
        end
        else
        begin
            bit_cnt_l <= bit_cnt_l + 3'h1;
            if (bit_cnt_l == 3'h0)
                frame_ctrl_l <= ~ctrl_frame_n_i;
            if (bit_cnt_l == 3'h7)
            begin
                rx_byte_l <= {rx_shift_l, spi_mosi_i};
                rx_framed_l <= frame_ctrl_l;
                rx_tgl_l <= ~rx_tgl_l;
            end
            else
                rx_shift_l <= {rx_shift_l[5:0], spi_mosi_i};
        end
    end

    // the outgoing byte is taken at the first rising edge; the core only
    // changes it after the frame-start toggle, so it is still when read
    always_ff @(posedge spi_sclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            spi_miso_o <= 1'b1;
            tx_shift_l <= 8'hFF;
            fs_tgl_l <= 1'b0;
        end
        else if (bit_cnt_l == 3'h0)
        begin
            spi_miso_o <= tx_byte_r[7];
            tx_shift_l <= {tx_byte_r[6:0], 1'b1};
            fs_tgl_l <= ~fs_tgl_l;
        end
        else
        begin
            spi_miso_o <= tx_shift_l[7];
            tx_shift_l <= {tx_shift_l[6:0], 1'b1};
        end
    end

    // ---------------------------------------------------------------
    // initialization, metering and answer train
    // ---------------------------------------------------------------
    logic [5:0] cyc_cnt_r;
    logic req_pend_r, train_on_r;
    logic [9:0] sent_r;
    logic [1:0] pos_r;
    logic qty_last;

    assign qty_last = ({1'b0, pos_r} == qty_size_i - 3'h1) || (qty_size_i == 3'h0);

    // framed bytes count toward the initialization block
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            init_cnt_r <= 8'h00;
            running_o <= 1'b0;
            metering_o <= 1'b0;
        end
        else
        begin
            running_o <= (state_r == ST_INIT) || (state_r == ST_METER);
            metering_o <= (state_r == ST_METER);
            if (state_r != ST_INIT)
                init_cnt_r <= 8'h00;
            else if (rx_evt && rx_framed_l)
                init_cnt_r <= init_cnt_r + 8'h01;
        end
    end

    // line cycles counted only while metering
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cyc_cnt_r <= 6'h00;
            compute_done_o <= 1'b0;
        end
        else
        begin
            compute_done_o <= 1'b0;
            if (state_r != ST_METER)
                cyc_cnt_r <= 6'h00;
            else if (line_evt && cyc_cnt_r == LINE_CYCLES - 6'h01)
            begin
                cyc_cnt_r <= 6'h00;
                compute_done_o <= 1'b1;
            end
            else if (line_evt)
                cyc_cnt_r <= cyc_cnt_r + 6'h01;
        end
    end

    // a request waits for the next computation; set wins over clear
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            req_pend_r <= 1'b0;
        else if (state_r != ST_METER)
            req_pend_r <= 1'b0;
        else if (rx_evt && rx_framed_l && rx_byte_l == REQ_CODE)
            req_pend_r <= 1'b1;
        else if (compute_done_o)
            req_pend_r <= 1'b0;
    end

    // outgoing byte: checksum during init, then the answer train;
    // any byte clocked after the checksum and outside a train reads as the idle value
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_byte_r <= IDLE_BYTE;
            train_on_r <= 1'b0;
            sent_r <= 10'h000;
            pos_r <= 2'h0;
            qty_index_o <= 7'h00;
            data_ready_flag_n_o <= 1'b1;
        end
        else if (state_r == ST_HOLD || (state_r != ST_INIT && state_r != ST_METER))
        begin
            tx_byte_r <= pick_byte(csum_r, QTY_BYTES_4, 2'h0);
            pos_r <= 2'h0;
            train_on_r <= 1'b0;
            data_ready_flag_n_o <= 1'b1;
        end
        else if (state_r == ST_INIT)
        begin
            if (fs_evt)
            begin
                // hold at the last checksum byte so later bytes read idle
                if ({6'h00, pos_r} < CSUM_BYTES - 8'h01)
                    pos_r <= pos_r + 2'h1;
                tx_byte_r <= ({6'h00, pos_r} < CSUM_BYTES - 8'h01) ?
                    pick_byte(csum_r, QTY_BYTES_4, pos_r + 2'h1) : IDLE_BYTE;
            end
        end
        else if (compute_done_o && req_pend_r)
        begin
            data_ready_flag_n_o <= 1'b0;
            train_on_r <= 1'b1;
            tx_byte_r <= REQ_CODE;
            sent_r <= 10'h000;
            pos_r <= 2'h0;
            qty_index_o <= 7'h00;
        end
        else if (fs_evt && train_on_r)
        begin
            data_ready_flag_n_o <= 1'b1;
            sent_r <= sent_r + 10'h001;
            if (sent_r == TRAIN_MAX - 10'h001)
            begin
                train_on_r <= 1'b0;
                tx_byte_r <= IDLE_BYTE;
            end
            else
            begin
                tx_byte_r <= pick_byte(qty_value_i, qty_size_i, pos_r);
                pos_r <= qty_last ? 2'h0 : pos_r + 2'h1;
                if (qty_last)
                    qty_index_o <= qty_index_o + 7'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_boot_on_strap:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_r == ST_HOLD && dev_rst_n_s && strap_s == 3'h0) |=> state_r == ST_BOOT_WAIT)
        else $error("boot not entered with straps low");

    a_segment_bound:
    assert property (@(posedge sys_clk_i) disable iff (rst_i) byte_cnt_r < seg_len(seg_r))
        else $error("segment byte count beyond its length");

    a_code_from_zero:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (seg_r == SEG_SETUP ##1 seg_r == SEG_CODE) |-> waddr_r == 13'h0000 && wbyte_r == 2'h0)
        else $error("code load does not restart at word zero");

    a_exec_after_load:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (byte_take && seg_r == SEG_CODE && last_of_seg) |=> boot_done_r ##[1:40] state_r == ST_INIT)
        else $error("execution did not start after last code byte");

    a_no_read_in_grant:
    assert property (@(posedge sys_clk_i) disable iff (rst_i) bus_grant_o |-> boot_memory_select_n_o)
        else $error("boot byte read while bus request asserted");

    a_select_follows:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        byte_take |=> !boot_memory_select_n_o && state_r == ST_BOOT_ACK)
        else $error("select strobe missing after byte read");

    a_init_gate:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(state_r == ST_METER) |-> $past(init_cnt_r) == INIT_BYTES - 8'h01)
        else $error("metering started before all init bytes");

    a_flag_on_calc:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(data_ready_flag_n_o) |-> $past(compute_done_o) && $past(req_pend_r))
        else $error("ready flag fell without request and computation");

    a_train_cap:
    assert property (@(posedge sys_clk_i) disable iff (rst_i) train_on_r |-> sent_r < TRAIN_MAX)
        else $error("answer train longer than allowed");

    a_framed_byte:
    assert property (@(negedge spi_sclk_i) disable iff (rst_i)
        (bit_cnt_l == 3'h0 && !ctrl_frame_n_i) ##7 (bit_cnt_l == 3'h7) |=> rx_framed_l)
        else $error("byte under control low not marked valid");

    c_boot_done: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(state_r == ST_INIT));
    c_metering: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(metering_o));
    c_flag_fall: cover property (@(posedge sys_clk_i) disable iff (rst_i) $fell(data_ready_flag_n_o));
    c_train_full: cover property (@(posedge sys_clk_i) disable iff (rst_i) $fell(train_on_r) && tx_byte_r == IDLE_BYTE);

endmodule : host_boot_and_spi_link

// *** bench/host_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// host: boot flip-flop and serial master
// ----------------------------------------
module host_model
(
    input wire logic sys_clk_i, // core clock, paces boot bytes
    input wire logic boot_memory_select_n_i, // presets the flip-flop
    output logic bus_request_n_o, // flip-flop output
    output logic [7:0] boot_data_o, // boot byte lines
    output logic spi_sclk_o, // link clock, still between bytes
    output logic spi_mosi_o, // serial data to device
    output logic ctrl_frame_n_o, // write framing line
    input wire logic spi_miso_i // serial data from device
);
    logic host_preset_data_line;
    logic host_flipflop_clock_line;

    // flip-flop: select strobe presets it, a clock edge loads inverted preset data
    always @(posedge host_flipflop_clock_line or negedge boot_memory_select_n_i)
        if (!boot_memory_select_n_i)
            bus_request_n_o <= 1'b0;
        else
            bus_request_n_o <= ~host_preset_data_line;

    // bus request asserted before any boot byte, link idle
    initial
    begin
        {spi_sclk_o, spi_mosi_o, ctrl_frame_n_o, boot_data_o} = {3'h3, 8'h00};
        {host_preset_data_line, host_flipflop_clock_line} = 2'h2;
        #1 host_flipflop_clock_line = 1'b1;
        // back low so the first release sees a rising edge
        #1 host_flipflop_clock_line = 1'b0;
    end

    // one boot byte: present, release, wait for the preset and the strobe to end
    task automatic boot_byte(input logic [7:0] b);
        int n;
        @(negedge sys_clk_i) boot_data_o = b;
        repeat (3) @(negedge sys_clk_i);
        {host_preset_data_line, host_flipflop_clock_line} = 2'h1;
        @(negedge sys_clk_i) host_flipflop_clock_line = 1'b0;
        n = 0;
        // bounded wait: request back low and strobe gone before next byte
        while ((bus_request_n_o || !boot_memory_select_n_i) && n < 50)
        begin
            @(negedge sys_clk_i) n++;
        end
        host_preset_data_line = 1'b1;
    endtask : boot_byte

    // one byte, msb first: change data on rise, sample on fall
    task automatic xfer(input logic framed, input logic [7:0] tx, output logic [7:0] rx);
        ctrl_frame_n_o = ~framed;
        for (int i = 7; i >= 0; i--)
        begin
            #40 spi_sclk_o = 1'b1;
            spi_mosi_o = tx[i];
            #40 spi_sclk_o = 1'b0;
            rx = {rx[6:0], spi_miso_i};
        end
        #40 ctrl_frame_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o; // released line must not keep its last value
        #40;
    endtask : xfer
endmodule : host_model

// *** bench/host_boot_and_spi_link_tb.sv ***
`timescale 1ns/100ps
module host_boot_and_spi_link_tb;
    logic sys_clk_i = 0, rst_i = 1, dev_reset_n_i = 0, line_cycle_i = 0;
    logic [2:0] boot_strap_i = 3'h0;
    logic brn, sel_n, grant, we, running, metering, cdone, flag_n, sclk, mosi, ctrl_n, miso;
    logic [7:0] bdata, rx;
    logic [12:0] addr;
    logic [23:0] word;
    logic [6:0] qidx;
    logic [31:0] vals [128];
    logic [7:0] img [12];
    logic [36:0] words [$];
    int err_count = 0, cmp_count = 0, ncd = 0;

    // ----------------------------------------
    // clock, parameter store, capture
    // ----------------------------------------
    always #4 sys_clk_i = ~sys_clk_i;

    // store answers in the same cycle, sizes repeat 4,2,1,2
    function automatic logic [2:0] size_of(input int i);
        return i % 4 == 0 ? 3'h4 : i % 2 == 1 ? 3'h2 : 3'h1;
    endfunction : size_of

    // count written words and compute pulses as they appear
    always @(posedge sys_clk_i)
    begin
        if (we === 1'b1) words.push_back({addr, word});
        if (cdone === 1'b1) ncd++;
    end

    host_boot_and_spi_link dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .dev_reset_n_i(dev_reset_n_i),
        .boot_strap_i(boot_strap_i), .bus_request_n_i(brn), .boot_data_i(bdata), .boot_memory_select_n_o(sel_n),
        .bus_grant_o(grant), .prog_we_o(we), .prog_addr_o(addr), .prog_word_o(word), .running_o(running),
        .metering_o(metering), .line_cycle_i(line_cycle_i), .compute_done_o(cdone), .qty_index_o(qidx),
        .qty_value_i(vals[qidx]), .qty_size_i(size_of(qidx)), .data_ready_flag_n_o(flag_n),
        .spi_sclk_i(sclk), .spi_mosi_i(mosi), .ctrl_frame_n_i(ctrl_n), .spi_miso_o(miso));
    host_model host_u (.sys_clk_i(sys_clk_i), .boot_memory_select_n_i(sel_n), .bus_request_n_o(brn),
        .boot_data_o(bdata), .spi_sclk_o(sclk), .spi_mosi_o(mosi), .ctrl_frame_n_o(ctrl_n), .spi_miso_i(miso));

    // ----------------------------------------
    // expectation, compare, verdict
    // ----------------------------------------
    // train byte after the echo: low word first, each word high byte first
    function automatic logic [7:0] exp_byte(input int p);
        int i;
        logic [31:0] v;
        i = 0;
        while (p >= size_of(i))
        begin
            p -= size_of(i);
            i++;
        end
        v = vals[i];
        if (size_of(i) == 3'h4) return p == 0 ? v[15:8] : p == 1 ? v[7:0] : p == 2 ? v[31:24] : v[23:16];
        return size_of(i) == 3'h2 && p == 0 ? v[15:8] : v[7:0];
    endfunction : exp_byte

    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    // line cycle input: one cycle per level is enough for the two-flop sync
    task automatic pulse_line(input int n);
        repeat (2 * n) @(negedge sys_clk_i) line_cycle_i = ~line_cycle_i;
        repeat (4) @(negedge sys_clk_i);
    endtask : pulse_line

    // a hang is cut short well past the expected run time
    initial
    begin
        #400000 err_count++;
        test_done();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        void'($urandom(81569));
        foreach (vals[i]) vals[i] = $urandom;
        foreach (img[i]) img[i] = 8'($urandom);
        repeat (10) @(negedge sys_clk_i);
        rst_i = 0;
        chk("select_n", 1, sel_n);
        chk("flag_n", 1, flag_n);
        repeat (4) @(negedge sys_clk_i) dev_reset_n_i = 1;
        repeat (6) @(negedge sys_clk_i);
        chk("grant", 1, grant);
        // the 12-byte image ends inside the header segment, so the pauses at bytes 95 and 338 never occur
        foreach (img[i])
        begin
            host_u.boot_byte(img[i]);
            if (i == 95 || i == 338) #1000000;
        end
        repeat (4) @(negedge sys_clk_i);
        chk("word count", 4, words.size());
        foreach (words[i]) chk("word", {13'(i), img[3*i], img[3*i+1], img[3*i+2]}, words[i]);
        chk("running", 0, running);
        $display("boot test done");
        dev_reset_n_i = 0;
        boot_strap_i = 3'h5;
        repeat (4) @(negedge sys_clk_i) dev_reset_n_i = 1;
        repeat (6) @(negedge sys_clk_i);
        chk("running", 1, running);
        host_u.xfer(0, 8'h45, rx);
        // no image loaded on this path, so the checksum bytes read zero
        for (int i = 0; i < 153; i++)
        begin
            host_u.xfer(1, i == 4 ? 8'h45 : 8'($urandom), rx);
            chk("checksum", i < 3 ? 8'h00 : 8'hFF, rx);
        end
        #400 chk("metering", 0, metering);
        host_u.xfer(1, 8'h00, rx);
        #400 chk("metering", 1, metering);
        $display("init test done");
        host_u.xfer(1, 8'h45, rx);
        ncd = 0;
        pulse_line(31);
        chk("compute", 0, ncd);
        chk("flag_n", 1, flag_n);
        pulse_line(1);
        chk("compute", 1, ncd);
        chk("flag_n", 0, flag_n);
        host_u.xfer(1, 8'hFF, rx);
        chk("train head", 8'h45, rx);
        chk("flag_n", 1, flag_n);
        for (int k = 0; k < 11; k++)
        begin
            host_u.xfer(1, 8'hFF, rx);
            chk("train byte", exp_byte(k), rx);
        end
        $display("train test done");
        test_done();
    end
endmodule : host_boot_and_spi_link_tb
